// file: sarseq_pkg.sv
package sarseq_pkg;

  // ****************************************************************
  // Register map (word aligned byte addresses)
  // ****************************************************************
  localparam logic [3:0] CTRL_OFS    = 4'h0; // converter_control_register
  localparam logic [3:0] CFG_OFS     = 4'h4; // converter_config_register
  localparam logic [3:0] CHAN_OFS    = 4'h8; // channel_select_register
  localparam logic [3:0] RESULT_OFS  = 4'hC; // result high:low bytes

  // Control register bit positions
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_DONE_BIT  = 5;
  localparam int CTRL_BUSY_BIT  = 4;
  localparam int CTRL_CM_LSB    = 0;
  localparam int CTRL_BURST_BIT = 6;

  // Config register field positions
  localparam int CFG_DIV_LSB = 3;  // sar_clock_divider, 5 bits
  localparam int CFG_RPT_LSB = 1;  // repeat count select, 2 bits
  localparam int CFG_TM_LSB  = 8;  // tracking_mode_select, 2 bits
  localparam int CFG_TK_LSB  = 10; // tracking_time_select, 2 bits
  localparam int CFG_PWR_LSB = 12; // power_up_time_select, 4 bits

  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CFG_RST  = 16'h01F8;
  localparam logic [4:0]  CHAN_RST = 5'h1F;

  // Cycle counts
  localparam logic [4:0] SAR_BITS     = 5'h0D; // SAR clocks per conversion
  localparam logic [4:0] EXTRA_SUB    = 5'h02; // start and finish cycles
  localparam logic [7:0] PWRUP_UNIT   = 8'h08; // cycles per power-up step
  localparam int         TIMER_MODE16 = 1;

  // Start source encodings
  typedef enum logic [1:0] {
    SRC_SOFT  = 2'b00,
    SRC_TMR_A = 2'b01,
    SRC_PIN   = 2'b10,
    SRC_TMR_B = 2'b11
  } sarseq_src_t;

  // Tracking mode encodings
  typedef enum logic [1:0] {
    TM_RSVD = 2'b00,
    TM_POST = 2'b01,
    TM_PRE  = 2'b10,
    TM_DUAL = 2'b11
  } sarseq_tm_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PWRUP = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV  = 3'b011,
    ST_DONE  = 3'b100
  } sarseq_state_t;

  // Timer overflow inputs grouped per timer
  typedef struct packed {
    logic mode16; // timer runs in 16-bit mode
    logic ovf_lo; // low byte overflow pulse
    logic ovf_hi; // high byte overflow pulse
  } sarseq_tmr_t;

  // Analog core control outputs
  typedef struct packed {
    logic       power;   // converter powered
    logic       track;   // sampling capacitor connected
    logic       convert; // SAR running
    logic       sar_clk; // SAR step enable
    logic [4:0] channel; // input_selector channel
  } sarseq_ana_t;

endpackage

// file: sarseq_top.sv
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps

// Contract
// - Converter powered when enable bit set or burst conversions run.
// - Shutdown when enable bit clear and no burst activity.
// - Start-source field picks software, timer A, pin edge or timer B.
// - Software start: writing 1 to busy bit starts one conversion.
// - Busy reads 1 during conversion; its fall sets done flag.
// - Timer trigger uses low overflow in 8-bit, high in 16-bit mode.
// - External start: each rising pin edge begins a conversion.
// - Result valid whenever done flag reads 1.
// - Mode 10b converts at once, tracks whenever not converting.
// - Mode 01b tracks programmed time, converts, then disconnects input.
// - Mode 11b tracks programmed time, converts, then keeps tracking.
// - Hardware tracking lasts tracking-time interval plus 2 cycles.
// - Conversion lasts 13 SAR clocks plus 2 subsystem clocks.
// - Subsystem clock from system clock, or burst oscillator in burst.
// - SAR clock is subsystem clock divided by divider field plus 1.
// - Always tracking, converting or idle; tracking goes straight on.
// - Burst powers up, samples, accumulates, then shuts down alone.
// - 27 single-ended ground-referenced sources chosen by channel field.
// - Burst start runs repeat-count conversions; done after all.
// - Burst from shutdown waits power-up time before tracking.
module sarseq_top (
  input  wire logic                   CLK_IN,
  input  wire logic                   RSTN_IN,
  input  wire logic [3:0]             AVS_ADDRESS_IN,
  input  wire logic                   AVS_READ_IN,
  input  wire logic                   AVS_WRITE_IN,
  input  wire logic [31:0]            AVS_WRITEDATA_IN,
  input  wire logic [3:0]             AVS_BYTEENABLE_IN,
  output logic      [31:0]            AVS_READDATA_OUT,
  output logic                        AVS_WAITREQUEST_OUT,
  input  wire sarseq_pkg::sarseq_tmr_t TMR_A_IN,
  input  wire sarseq_pkg::sarseq_tmr_t TMR_B_IN,
  input  wire logic                   EXT_START_IN,
  input  wire logic                   BURST_CLK_EN_IN,
  input  wire logic [11:0]            SAR_CODE_IN,
  output sarseq_pkg::sarseq_ana_t     ANA_OUT,
  output logic                        BUSY_OUT,
  output logic                        DONE_OUT
);
  import sarseq_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Tracking interval in subsystem cycles, plus the 2 fixed cycles
  function automatic logic [7:0] track_len(input logic [1:0] tk);
    track_len = 8'((8'h01 << (3'(tk) + 3'h1)) + 8'(EXTRA_SUB));
  endfunction

  // Number of conversions in one burst
  function automatic logic [4:0] rpt_count(input logic [1:0] r);
    case (r)
      2'b00:   rpt_count = 5'h01;
      2'b01:   rpt_count = 5'h04;
      2'b10:   rpt_count = 5'h08;
      default: rpt_count = 5'h10;
    endcase
  endfunction

  logic [7:0]  ctrl_reg;
  logic [15:0] cfg_reg;
  logic [4:0]  chan_reg;
  logic [15:0] result_reg;
  logic [15:0] acc_reg;
  logic        busy_reg;
  logic        done_reg;
  logic        soft_start;
  logic        ack_reg;
  logic        ext_s1_reg;
  logic        ext_s2_reg;
  logic        ext_d_reg;
  logic [4:0]  div_cnt_reg;
  logic        sar_tick;
  logic        sub_tick;
  logic        start_raw;
  logic        start_go;
  logic        finish;
  logic [7:0]  cnt_reg;
  logic [4:0]  sar_cnt_reg;
  logic [4:0]  rpt_left_reg;
  sarseq_state_t state_reg;
  sarseq_tm_t    tm;
  logic          burst;
  logic          hit;

  assign tm    = sarseq_tm_t'(cfg_reg[CFG_TM_LSB +: 2]);
  assign burst = ctrl_reg[CTRL_BURST_BIT];
  assign hit   = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_reg;

  // ****************************************************************
  // Avalon slave: one wait cycle, answer on the second edge
  // ****************************************************************
  // Waitrequest high until the access is acknowledged
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_reg             <= 1'b0;
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      ack_reg             <= hit;
      AVS_WAITREQUEST_OUT <= ~hit;
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (hit && AVS_READ_IN) begin
      case (AVS_ADDRESS_IN)
        CTRL_OFS:   AVS_READDATA_OUT <= {24'h000000, ctrl_reg[7:6],
                                         done_reg, busy_reg,
                                         ctrl_reg[3:0]};
        CFG_OFS:    AVS_READDATA_OUT <= {16'h0000, cfg_reg};
        CHAN_OFS:   AVS_READDATA_OUT <= {27'h0000000, chan_reg};
        RESULT_OFS: AVS_READDATA_OUT <= {16'h0000, result_reg};
        default:    AVS_READDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // Writable configuration; busy and done handled below
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_reg <= CTRL_RST;
      cfg_reg  <= CFG_RST;
      chan_reg <= CHAN_RST;
    end else if (hit && AVS_WRITE_IN) begin
      if (AVS_ADDRESS_IN == CTRL_OFS && AVS_BYTEENABLE_IN[0]) begin
        ctrl_reg <= AVS_WRITEDATA_IN[7:0];
      end
      if (AVS_ADDRESS_IN == CFG_OFS) begin
        if (AVS_BYTEENABLE_IN[0]) cfg_reg[7:0] <= AVS_WRITEDATA_IN[7:0];
        if (AVS_BYTEENABLE_IN[1]) cfg_reg[15:8] <= AVS_WRITEDATA_IN[15:8];
      end
      if (AVS_ADDRESS_IN == CHAN_OFS && AVS_BYTEENABLE_IN[0]) begin
        chan_reg <= AVS_WRITEDATA_IN[4:0];
      end
    end
  end

  assign soft_start = hit && AVS_WRITE_IN && AVS_ADDRESS_IN == CTRL_OFS
                      && AVS_BYTEENABLE_IN[0]
                      && AVS_WRITEDATA_IN[CTRL_BUSY_BIT];

  // ****************************************************************
  // Start sources
  // ****************************************************************
  // Pin crosses in through two flops before the edge detector
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg  <= 1'b0;
    end else begin
      ext_s1_reg <= EXT_START_IN;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg  <= ext_s2_reg;
    end
  end

  // Pick one trigger; timers use the byte that matches their width
  always_comb begin
    case (sarseq_src_t'(ctrl_reg[CTRL_CM_LSB +: 2]))
      SRC_SOFT:  start_raw = soft_start;
      SRC_TMR_A: start_raw = TMR_A_IN.mode16 ? TMR_A_IN.ovf_hi
                                             : TMR_A_IN.ovf_lo;
      SRC_PIN:   start_raw = ext_s2_reg & ~ext_d_reg;
      SRC_TMR_B: start_raw = TMR_B_IN.mode16 ? TMR_B_IN.ovf_hi
                                             : TMR_B_IN.ovf_lo;
      default:   start_raw = 1'b0;
    endcase
  end

  // Reserved mode and busy sequencer drop the start
  assign start_go = start_raw && tm != TM_RSVD
                    && (ctrl_reg[CTRL_EN_BIT] || burst)
                    && state_reg == ST_IDLE;

  // ****************************************************************
  // Subsystem and SAR clock enables
  // ****************************************************************
  // Burst mode steps on the oscillator's enable pulse instead
  assign sub_tick = burst ? BURST_CLK_EN_IN : 1'b1;

  // SAR step every divider+1 cycles; held until the start cycles pass
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      div_cnt_reg <= 5'h00;
    end else if (state_reg != ST_CONV) begin
      div_cnt_reg <= 5'h00;
    end else if (sub_tick && cnt_reg == 8'h00) begin
      if (div_cnt_reg == cfg_reg[CFG_DIV_LSB +: 5]) begin
        div_cnt_reg <= 5'h00;
      end else begin
        div_cnt_reg <= div_cnt_reg + 5'h01;
      end
    end
  end
  assign sar_tick = sub_tick && state_reg == ST_CONV && cnt_reg == 8'h00
                    && sar_cnt_reg != SAR_BITS // No step in finish cycle
                    && div_cnt_reg == cfg_reg[CFG_DIV_LSB +: 5];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // cnt_reg counts subsystem cycles; sar_cnt_reg counts SAR steps
  assign finish = sub_tick && state_reg == ST_CONV && cnt_reg == 8'h00
                  && sar_cnt_reg == SAR_BITS;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 8'h00;
      sar_cnt_reg  <= 5'h00;
      rpt_left_reg <= 5'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_go) begin
            rpt_left_reg <= burst ? rpt_count(cfg_reg[CFG_RPT_LSB +: 2])
                                  : 5'h01;
            if (burst && !ctrl_reg[CTRL_EN_BIT]) begin
              state_reg <= ST_PWRUP;
              cnt_reg   <= 8'(cfg_reg[CFG_PWR_LSB +: 4] * PWRUP_UNIT);
            end else if (tm == TM_PRE) begin
              state_reg <= ST_CONV;
              cnt_reg   <= 8'(EXTRA_SUB - 5'h01);
            end else begin
              state_reg <= ST_TRACK;
              cnt_reg   <= track_len(cfg_reg[CFG_TK_LSB +: 2]) - 8'h01;
            end
            sar_cnt_reg <= 5'h00;
          end
        end
        ST_PWRUP: if (sub_tick) begin
          if (cnt_reg == 8'h00) begin
            state_reg <= ST_TRACK;
            cnt_reg   <= track_len(cfg_reg[CFG_TK_LSB +: 2]) - 8'h01;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_TRACK: if (sub_tick) begin
          if (cnt_reg == 8'h00) begin
            state_reg <= ST_CONV;
            cnt_reg   <= 8'(EXTRA_SUB - 5'h01);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_CONV: if (sub_tick) begin
          if (finish) begin
            if (rpt_left_reg > 5'h01) begin
              rpt_left_reg <= rpt_left_reg - 5'h01;
              state_reg    <= ST_TRACK;
              cnt_reg <= track_len(cfg_reg[CFG_TK_LSB +: 2]) - 8'h01;
              sar_cnt_reg  <= 5'h00;
            end else begin
              state_reg <= ST_DONE;
            end
          end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (sar_tick) begin
            sar_cnt_reg <= sar_cnt_reg + 5'h01;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Accumulate each code; result loads once the series ends
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      acc_reg    <= 16'h0000;
      result_reg <= 16'h0000;
    end else if (start_go) begin
      acc_reg <= 16'h0000;
    end else if (finish) begin
      acc_reg <= acc_reg + {4'h0, SAR_CODE_IN};
    end else if (state_reg == ST_DONE) begin
      result_reg <= acc_reg;
    end
  end

  // Busy follows the sequence; its fall sets done, set beats clear
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      busy_reg <= start_go || (busy_reg && state_reg != ST_DONE);
      if (busy_reg && state_reg == ST_DONE) begin
        done_reg <= 1'b1;
      end else if (soft_start || (hit && AVS_WRITE_IN
                   && AVS_ADDRESS_IN == CTRL_OFS && AVS_BYTEENABLE_IN[0]
                   && !AVS_WRITEDATA_IN[CTRL_DONE_BIT])) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  // Tracking after conversion depends on mode; post mode floats input
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ANA_OUT  <= '0;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
    end else begin
      ANA_OUT.power   <= ctrl_reg[CTRL_EN_BIT]
                         || (burst && state_reg != ST_IDLE);
      ANA_OUT.track   <= state_reg == ST_TRACK
                         || (state_reg == ST_IDLE && ctrl_reg[CTRL_EN_BIT]
                             && (tm == TM_PRE || tm == TM_DUAL));
      ANA_OUT.convert <= state_reg == ST_CONV;
      ANA_OUT.sar_clk <= sar_tick;
      ANA_OUT.channel <= chan_reg;
      BUSY_OUT        <= busy_reg;
      DONE_OUT        <= done_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_idle_start;
    state_reg == ST_IDLE && start_go;
  endsequence

  property p_shutdown;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (!ctrl_reg[CTRL_EN_BIT] && state_reg == ST_IDLE && !burst)
      |=> !ANA_OUT.power;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("power leak");

  property p_busy_rise;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    s_idle_start |=> busy_reg;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy low");

  property p_done_fall;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    $fell(busy_reg) |-> done_reg;
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("no done");

  property p_pre_direct;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (s_idle_start and (tm == TM_PRE && !burst)) |=> state_reg == ST_CONV;
  endproperty
  a_pre_direct: assert property (p_pre_direct) else $error("pre mode");

  property p_rsvd;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    tm == TM_RSVD && state_reg == ST_IDLE |=> state_reg == ST_IDLE;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved ran");

  property p_no_restart;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    state_reg == ST_CONV && !finish |=> state_reg == ST_CONV;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart");

  property p_track_conv;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    state_reg == ST_TRACK |=> state_reg inside {ST_TRACK, ST_CONV};
  endproperty
  a_track_conv: assert property (p_track_conv) else $error("gap");

  property p_sar_steps;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    finish |-> sar_cnt_reg == SAR_BITS;
  endproperty
  a_sar_steps: assert property (p_sar_steps) else $error("sar count");

  property p_post_float;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    state_reg == ST_IDLE && tm == TM_POST |=> !ANA_OUT.track;
  endproperty
  a_post_float: assert property (p_post_float) else $error("tracked");

endmodule

// file: sarseq_top_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end

module sarseq_top_test;
  import sarseq_pkg::*;

  logic              clk;
  logic              rstn;
  logic [3:0]        adr;
  logic              rd;
  logic              wr;
  logic [31:0]       wdat;
  logic [31:0]       rdat;
  logic              wait_req;
  sarseq_tmr_t       tmr_a;
  sarseq_tmr_t       tmr_b;
  logic              ext_start;
  logic              bclk_en = 1'b0;
  logic [11:0]       code;
  sarseq_ana_t       ana;
  logic              busy;
  logic              done;
  logic [31:0]       rv;
  int                error_cnt;
  int                n_checks;
  int                sar;
  int                trk;
  int                gap;
  int                pw0;
  int                tr0;
  int                cv;

  sarseq_top u_dut (
    .CLK_IN              (clk),
    .RSTN_IN             (rstn),
    .AVS_ADDRESS_IN      (adr),
    .AVS_READ_IN         (rd),
    .AVS_WRITE_IN        (wr),
    .AVS_WRITEDATA_IN    (wdat),
    .AVS_BYTEENABLE_IN   (4'hF),
    .AVS_READDATA_OUT    (rdat),
    .AVS_WAITREQUEST_OUT (wait_req),
    .TMR_A_IN            (tmr_a),
    .TMR_B_IN            (tmr_b),
    .EXT_START_IN        (ext_start),
    .BURST_CLK_EN_IN     (bclk_en),
    .SAR_CODE_IN         (code),
    .ANA_OUT             (ana),
    .BUSY_OUT            (busy),
    .DONE_OUT            (done)
  );

  // ****************************************************************
  // Clock and burst oscillator tick
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Tick every other cycle, so burst timing differs from system timing
  always @(posedge clk) begin
    bclk_en <= ~bclk_en;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One bus access; held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    if (i == 50) begin
      error_cnt++;
      close_out();
    end
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Watch one sequence up to the done flag, counting phases
  task automatic conv();
    int i;
    int last;
    sar  = 0;
    trk  = 0;
    cv   = 0;
    gap  = 0;
    pw0  = -1;
    tr0  = -1;
    last = -1;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (ana.sar_clk === 1'b1) begin
        sar++;
        gap  = i - last;
        last = i;
      end
      if (ana.track === 1'b1 && busy === 1'b1) trk++;
      if (ana.convert === 1'b1) cv++;
      if (ana.power === 1'b1 && pw0 < 0) pw0 = i;
      if (ana.track === 1'b1 && tr0 < 0) tr0 = i;
      if (done === 1'b1) break;
    end
    if (i == 3000) begin
      error_cnt++;
      close_out();
    end
  endtask

  // Timer overflow pulse, one cycle wide
  task automatic tpulse(input bit b, input logic m, lo, hi);
    @(posedge clk);
    if (b) tmr_b <= '{m, lo, hi};
    else tmr_a <= '{m, lo, hi};
    @(posedge clk);
    tmr_a <= '{m, 1'b0, 1'b0};
    tmr_b <= '{m, 1'b0, 1'b0};
  endtask

  function automatic logic [31:0] cw(logic en, bu, st, logic [1:0] src);
    return {24'h0, en, bu, 1'b0, st, 2'b00, src};
  endfunction

  function automatic logic [31:0] cf(logic [3:0] pw, logic [1:0] tk,
      sarseq_tm_t tm, logic [4:0] dv, logic [1:0] rp);
    return {16'h0, pw, tk, tm, dv, rp, 1'b0};
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0; adr = 4'h0; rd = 1'b0; wr = 1'b0; wdat = 32'h0;
    tmr_a = '0; tmr_b = '0; ext_start = 1'b0;
    code = 12'h000; error_cnt = 0; n_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, unmapped place, power off
    av(1'b0, CTRL_OFS, 32'h0); `CHK(rv, {24'h0, CTRL_RST})
    av(1'b0, CFG_OFS, 32'h0); `CHK(rv, {16'h0, CFG_RST})
    av(1'b0, CHAN_OFS, 32'h0); `CHK(rv, {27'h0, CHAN_RST})
    av(1'b0, RESULT_OFS, 32'h0); `CHK(rv, 32'h0)
    `CHK(ana.power, 1'b0)
    av(1'b1, 4'h2, 32'hFFFF_FFFF);
    av(1'b0, 4'h2, 32'h0); `CHK(rv, 32'h0)
    av(1'b0, CTRL_OFS, 32'h0); `CHK(rv, 32'h0)
    // Channel field is 5 bits wide
    av(1'b1, CHAN_OFS, 32'hFF);
    av(1'b0, CHAN_OFS, 32'h0); `CHK(rv, 32'h1F)
    av(1'b1, CHAN_OFS, 32'h05);
    av(1'b0, CHAN_OFS, 32'h0); `CHK(ana.channel, 5'h05)
    // Enable powers up; reserved mode refuses starts
    av(1'b1, CFG_OFS, cf(4'h0, 2'h0, TM_RSVD, 5'h00, 2'h0));
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b0, SRC_SOFT));
    av(1'b0, CTRL_OFS, 32'h0); `CHK(ana.power, 1'b1)
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b1, SRC_SOFT));
    repeat (8) @(posedge clk);
    `CHK(busy, 1'b0)
    // Post tracking, shortest interval, soft start
    code <= 12'hA5C;
    av(1'b1, CFG_OFS, cf(4'h0, 2'h0, TM_POST, 5'h00, 2'h0));
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b1, SRC_SOFT));
    conv();
    `CHK(trk, 4)
    `CHK(sar, 13)
    `CHK(cv, 15)
    `CHK(busy, 1'b0)
    `CHK(ana.track, 1'b0)
    av(1'b0, RESULT_OFS, 32'h0); `CHK(rv, 32'h0000_0A5C)
    // Dual tracking, longer interval, divided SAR clock, retrigger
    code <= 12'h3C1;
    av(1'b1, CFG_OFS, cf(4'h0, 2'h2, TM_DUAL, 5'h02, 2'h0));
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b0, SRC_TMR_A));
    fork
      conv();
      begin
        tpulse(1'b0, 1'b0, 1'b1, 1'b0);
        repeat (6) @(posedge clk);
        tpulse(1'b0, 1'b0, 1'b1, 1'b0);
      end
    join
    `CHK(trk, 10)
    `CHK(sar, 13)
    `CHK(cv, 41)
    `CHK(gap, 3)
    `CHK(ana.track, 1'b1)
    av(1'b0, RESULT_OFS, 32'h0); `CHK(rv, 32'h0000_03C1)
    // Pre tracking converts at once, tracks while idle
    av(1'b1, CFG_OFS, cf(4'h0, 2'h3, TM_PRE, 5'h00, 2'h0));
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b0, SRC_SOFT));
    `CHK(ana.track, 1'b1)
    tpulse(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(busy, 1'b0)
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b1, SRC_SOFT));
    conv();
    `CHK(trk, 0)
    `CHK(sar, 13)
    // Both timers in both widths; the wrong overflow is ignored
    for (int k = 0; k < 4; k++) begin
      av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b0,
         k[1] ? SRC_TMR_B : SRC_TMR_A));
      tpulse(k[1], k[0], k[0], ~k[0]);
      repeat (8) @(posedge clk);
      `CHK(busy, 1'b0)
      fork
        conv();
        tpulse(k[1], k[0], ~k[0], k[0]);
      join
      `CHK(sar, 13)
    end
    // External pin rising edge
    av(1'b1, CTRL_OFS, cw(1'b1, 1'b0, 1'b0, SRC_PIN));
    fork
      conv();
      begin
        @(posedge clk);
        ext_start <= 1'b1;
      end
    join
    `CHK(sar, 13)
    ext_start <= 1'b0;
    // Burst from shutdown, four conversions, power-up wait
    av(1'b1, CFG_OFS, cf(4'h1, 2'h0, TM_POST, 5'h00, 2'h1));
    av(1'b1, CTRL_OFS, cw(1'b0, 1'b1, 1'b0, SRC_SOFT));
    repeat (4) @(posedge clk);
    `CHK(ana.power, 1'b0)
    av(1'b1, CTRL_OFS, cw(1'b0, 1'b1, 1'b1, SRC_SOFT));
    conv();
    `CHK(sar, 52)
    `CHK(tr0 - pw0 >= 16, 1'b1)
    repeat (8) @(posedge clk);
    `CHK(ana.power, 1'b0)
    // Four equal codes accumulate into one result
    av(1'b0, RESULT_OFS, 32'h0); `CHK(rv, 32'h0000_0F04)
    close_out();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule
